//--- osd_pixel_colour_attribute_resolver.sv
// pixel colour resolver: attributes, colour table, brightness, blanking
module osd_pixel_colour_attribute_resolver (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // character stream from display memory
  input  wire logic        row_start,
  input  wire logic        char_valid,
  input  wire logic [11:0] char_word,
  // pixel stream from font fetch and timing
  input  wire logic        pixel_en,
  input  wire logic        glyph_plane_low,
  input  wire logic        glyph_plane_high,
  input  wire logic        line_top,
  input  wire logic        line_bottom,
  input  wire logic        line_odd,
  input  wire logic        in_text_area,
  input  wire logic        flyback,
  // to the rgb dacs and video switch
  output logic      [11:0] rgb_out,
  output logic             fast_blank_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  display_ctrl;
  logic [4:0]  bright_ctrl;
  logic [5:0]  text_start;
  logic [5:0]  text_end;
  logic [11:0] colour_table [osd_colour_pkg::colour_entries];

  logic        dphase_write;
  logic [7:0]  dphase_addr;
  logic        addr_take;

  logic [1:0]  screen_mode_bits;
  logic        screen_mode_low;
  logic        screen_mode_high;
  logic        mesh_enable;
  logic [3:0]  screen_colour;
  logic [3:0]  rgb_brightness_level;
  logic        blank_polarity_sel;
  osd_colour_pkg::screen_mode_type screen_mode;

  assign screen_mode_bits     = display_ctrl[osd_colour_pkg::mode_lsb +: 2];
  assign screen_mode_low      = screen_mode_bits[0];
  assign screen_mode_high     = screen_mode_bits[1];
  assign mesh_enable          = display_ctrl[osd_colour_pkg::mesh_bit];
  assign screen_colour        = display_ctrl[osd_colour_pkg::screen_lsb +: 4];
  assign rgb_brightness_level = bright_ctrl[osd_colour_pkg::bright_lsb +: 4];
  assign blank_polarity_sel   = bright_ctrl[osd_colour_pkg::polarity_bit];

  always_comb begin
    case ({screen_mode_high, screen_mode_low})
      2'b00:   screen_mode = osd_colour_pkg::mode_video;
      2'b01:   screen_mode = osd_colour_pkg::mode_full_text;
      2'b10:   screen_mode = osd_colour_pkg::mode_mixed_scr;
      2'b11:   screen_mode = osd_colour_pkg::mode_mixed_video;
      default: screen_mode = osd_colour_pkg::mode_video;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave: zero wait states, always okay
  // ----------------------------------------------------------------
  assign addr_take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_write <= 1'b0;
      dphase_addr  <= 8'h00;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      dphase_write <= addr_take && hwrite && (hsize == 3'h2);
      dphase_addr  <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_ctrl <= osd_colour_pkg::ctrl_reset;
      bright_ctrl  <= osd_colour_pkg::bright_reset;
      text_start   <= osd_colour_pkg::text_start_rst;
      text_end     <= osd_colour_pkg::text_end_rst;
    end else if (dphase_write) begin
      case (dphase_addr)
        osd_colour_pkg::display_ctrl_addr: display_ctrl <= hwdata[7:0];
        osd_colour_pkg::brightness_addr:   bright_ctrl  <= hwdata[4:0];
        osd_colour_pkg::text_start_addr:   text_start   <= hwdata[5:0];
        osd_colour_pkg::text_end_addr:     text_end     <= hwdata[5:0];
        default: ;
      endcase
    end
  end

  // colour table has no reset: software loads it before display
  always_ff @(posedge hclk) begin
    if (dphase_write && dphase_addr >= osd_colour_pkg::colour_table_addr
        && dphase_addr <= osd_colour_pkg::colour_table_last) begin
      colour_table[dphase_addr[5:2]] <= hwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // row attribute state
  // ----------------------------------------------------------------
  logic [2:0] fg_code;
  logic       bank;
  logic [3:0] bg_colour;
  logic       underline;
  logic       overline;
  logic       boxed;
  logic       flash;
  logic       italics;
  logic       fringing;
  logic       size_h;
  logic       size_v;
  logic       duration;
  logic       end_row;
  logic       row_active;
  logic [5:0] column;
  logic       cell_serial;
  logic       cell_special;
  logic       pend_valid;
  logic [3:0] pend_bg;
  logic       pend_ul;
  logic       pend_ol;
  logic       pend_box;
  logic       pend_bank;

  logic [5:0] span;
  logic       char_take;
  logic       is_serial;
  logic       is_mode1;
  logic       first_pos;

  assign span      = 6'(text_end - text_start);
  assign char_take = char_valid && row_active;
  assign is_serial = char_word[osd_colour_pkg::code_mode_bit];
  assign is_mode1  = char_word[osd_colour_pkg::serial_mode_bit];
  assign first_pos = (column == 6'h00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fg_code      <= osd_colour_pkg::row_fg_reset;
      bank         <= 1'b0;
      bg_colour    <= osd_colour_pkg::row_bg_reset;
      underline    <= 1'b0;
      overline     <= 1'b0;
      boxed        <= 1'b0;
      flash        <= 1'b0;
      italics      <= 1'b0;
      fringing     <= 1'b0;
      size_h       <= 1'b0;
      size_v       <= 1'b0;
      duration     <= 1'b0;
      end_row      <= 1'b0;
      row_active   <= 1'b0;
      column       <= 6'h00;
      cell_serial  <= 1'b0;
      cell_special <= 1'b0;
      pend_valid   <= 1'b0;
      pend_bg      <= 4'h0;
      pend_ul      <= 1'b0;
      pend_ol      <= 1'b0;
      pend_box     <= 1'b0;
      pend_bank    <= 1'b0;
    end else if (row_start) begin
      fg_code      <= osd_colour_pkg::row_fg_reset;
      bank         <= 1'b0;
      bg_colour    <= osd_colour_pkg::row_bg_reset;
      underline    <= 1'b0;
      overline     <= 1'b0;
      boxed        <= 1'b0;
      flash        <= 1'b0;
      italics      <= 1'b0;
      fringing     <= 1'b0;
      size_h       <= 1'b0;
      size_v       <= 1'b0;
      duration     <= 1'b0;
      end_row      <= 1'b0;
      row_active   <= 1'b1;
      column       <= 6'h00;
      cell_serial  <= 1'b0;
      cell_special <= 1'b0;
      pend_valid   <= 1'b0;
    end else if (char_take) begin
      column <= column + 6'h01;
      // the span limit closes the row after its last allowed cell
      if (column == span) begin
        row_active <= 1'b0;
      end
      // attributes deferred by a mode-1 code land on this cell
      if (pend_valid) begin
        bg_colour  <= pend_bg;
        underline  <= pend_ul;
        overline   <= pend_ol;
        boxed      <= pend_box;
        bank       <= pend_bank;
        pend_valid <= 1'b0;
      end
      cell_serial <= is_serial;
      if (!is_serial) begin
        fg_code      <= char_word[osd_colour_pkg::fg_lsb +: 3];
        cell_special <= (char_word[7:4] == osd_colour_pkg::special_col_lo
                         || char_word[7:4] == osd_colour_pkg::special_col_hi)
                        && !char_word[0];
      end else begin
        cell_special <= 1'b0;
        if (!is_mode1) begin
          bg_colour <= char_word[3:0];
          underline <= char_word[4];
          overline  <= char_word[5];
          boxed     <= char_word[6];
          flash     <= char_word[7];
          italics   <= char_word[8];
          fringing  <= char_word[9];
        end else begin
          duration <= char_word[8];
          end_row  <= char_word[9];
          if (char_word[9]) begin
            row_active <= 1'b0;
          end
          if (first_pos) begin
            bg_colour <= char_word[3:0];
            size_h    <= char_word[4];
            size_v    <= char_word[5];
            boxed     <= char_word[6];
            bank      <= char_word[7];
          end else begin
            pend_valid <= 1'b1;
            pend_bg    <= char_word[3:0];
            pend_ul    <= char_word[4];
            pend_ol    <= char_word[5];
            pend_box   <= char_word[6];
            pend_bank  <= char_word[7];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pixel colour resolution
  // ----------------------------------------------------------------
  logic       mesh_phase;
  logic       in_cell;
  logic       extend_bg;
  logic       mixed;
  logic       fg_pixel;
  logic       show_bg;
  logic       transparent;
  logic [3:0] pixel_index;
  logic [11:0] table_colour;
  logic [3:0] scaled_red;
  logic [3:0] scaled_green;
  logic [3:0] scaled_blue;

  // pixel parity restarts each line so the line parity sets the phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mesh_phase <= 1'b0;
    end else if (flyback) begin
      mesh_phase <= 1'b0;
    end else if (pixel_en) begin
      mesh_phase <= ~mesh_phase;
    end
  end

  assign in_cell   = in_text_area && row_active && !row_start;
  assign extend_bg = in_text_area && !row_active && duration && end_row;
  assign mixed     = (screen_mode == osd_colour_pkg::mode_mixed_scr)
                  || (screen_mode == osd_colour_pkg::mode_mixed_video);

  // fringing is never generated here, so glyph cells carry none either
  always_comb begin
    fg_pixel    = 1'b0;
    show_bg     = 1'b0;
    transparent = 1'b0;
    pixel_index = screen_colour;
    if (in_cell || extend_bg) begin
      if (in_cell && !cell_serial) begin
        fg_pixel = glyph_plane_low || (cell_special && glyph_plane_high);
      end
      // line forcing also covers spaces and the extended tail
      if ((underline && line_bottom) || (overline && line_top)) begin
        fg_pixel = 1'b1;
      end
      show_bg = (screen_mode == osd_colour_pkg::mode_full_text) || (mixed && boxed);
      if (show_bg && mesh_enable && (mesh_phase ^ line_odd)) begin
        show_bg = 1'b0;
      end
    end
    if (fg_pixel) begin
      if (in_cell && cell_special && glyph_plane_high) begin
        pixel_index = {bank, glyph_plane_low ? osd_colour_pkg::glyph_colour_b
                                             : osd_colour_pkg::glyph_colour_a};
      end else begin
        pixel_index = {bank, fg_code};
      end
    end else if (show_bg) begin
      pixel_index = bg_colour;
    end else if (screen_mode == osd_colour_pkg::mode_mixed_video) begin
      transparent = 1'b1;
    end
  end

  assign table_colour = colour_table[pixel_index];

  channel_level_scale red_scale (
    .level_in             (table_colour[osd_colour_pkg::red_lsb +: 4]),
    .rgb_brightness_level (rgb_brightness_level),
    .level_out            (scaled_red)
  );

  channel_level_scale green_scale (
    .level_in             (table_colour[osd_colour_pkg::green_lsb +: 4]),
    .rgb_brightness_level (rgb_brightness_level),
    .level_out            (scaled_green)
  );

  channel_level_scale blue_scale (
    .level_in             (table_colour[osd_colour_pkg::blue_lsb +: 4]),
    .rgb_brightness_level (rgb_brightness_level),
    .level_out            (scaled_blue)
  );

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // fly-back is tested first so no attribute can leak into blanking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rgb_out        <= osd_colour_pkg::fly_normal;
      fast_blank_out <= 1'b0;
    end else if (flyback) begin
      rgb_out        <= blank_polarity_sel ? osd_colour_pkg::fly_inverted
                                           : osd_colour_pkg::fly_normal;
      fast_blank_out <= blank_polarity_sel;
    end else if (screen_mode == osd_colour_pkg::mode_video || transparent) begin
      rgb_out        <= osd_colour_pkg::fly_normal;
      fast_blank_out <= blank_polarity_sel;
    end else begin
      rgb_out        <= {scaled_red, scaled_green, scaled_blue};
      fast_blank_out <= ~blank_polarity_sel;
    end
  end

  // ----------------------------------------------------------------
  // read data, registered in the address phase
  // ----------------------------------------------------------------
  logic [31:0] next_hrdata;

  always_comb begin
    next_hrdata = 32'h0000_0000;
    case (haddr)
      osd_colour_pkg::display_ctrl_addr: next_hrdata = {24'h00_0000, display_ctrl};
      osd_colour_pkg::brightness_addr:   next_hrdata = {27'h000_0000, bright_ctrl};
      osd_colour_pkg::text_start_addr:   next_hrdata = {26'h000_0000, text_start};
      osd_colour_pkg::text_end_addr:     next_hrdata = {26'h000_0000, text_end};
      osd_colour_pkg::status_addr: begin
        next_hrdata = {7'h00, flash, italics, fringing, size_h, size_v,
                       column, row_active, end_row, duration, boxed,
                       overline, underline, bank, fg_code, bg_colour};
      end
      default: begin
        if (haddr >= osd_colour_pkg::colour_table_addr
            && haddr <= osd_colour_pkg::colour_table_last) begin
          next_hrdata = {20'h0_0000, colour_table[haddr[5:2]]};
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

endmodule

//--- osd_colour_pkg.sv
// shared constants for the caption pixel colour resolver
package osd_colour_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] display_ctrl_addr = 8'h00;
  localparam logic [7:0] brightness_addr   = 8'h04;
  localparam logic [7:0] text_start_addr   = 8'h08;
  localparam logic [7:0] text_end_addr     = 8'h0c;
  localparam logic [7:0] status_addr       = 8'h10;
  localparam logic [7:0] colour_table_addr = 8'h40;
  localparam logic [7:0] colour_table_last = 8'h7c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int mode_lsb        = 0;
  localparam int mesh_bit        = 2;
  localparam int screen_lsb      = 4;
  localparam int bright_lsb      = 0;
  localparam int polarity_bit    = 4;
  localparam int red_lsb         = 8;
  localparam int green_lsb       = 4;
  localparam int blue_lsb        = 0;
  localparam int code_mode_bit   = 11;
  localparam int serial_mode_bit = 10;
  localparam int fg_lsb          = 8;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int colour_entries         = 16;
  localparam int colour_width           = 12;
  localparam logic [3:0] row_bg_reset   = 4'h8;
  localparam logic [2:0] row_fg_reset   = 3'h0;
  localparam logic [3:0] special_col_lo = 4'h8;
  localparam logic [3:0] special_col_hi = 4'h9;
  localparam logic [2:0] glyph_colour_a = 3'h6;
  localparam logic [2:0] glyph_colour_b = 3'h7;
  localparam logic [11:0] fly_normal    = 12'h000;
  localparam logic [11:0] fly_inverted  = 12'hfff;
  localparam logic [7:0] ctrl_reset     = 8'h00;
  localparam logic [4:0] bright_reset   = 5'h0f;
  localparam logic [5:0] text_start_rst = 6'h00;
  localparam logic [5:0] text_end_rst   = 6'h2f;

  // ----------------------------------------------------------------
  // screen modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    mode_video       = 4'b0001,
    mode_full_text   = 4'b0010,
    mode_mixed_scr   = 4'b0100,
    mode_mixed_video = 4'b1000
  } screen_mode_type;

endpackage

//--- channel_level_scale.sv
// scales one 4-bit colour channel by the brightness level
module channel_level_scale (
  // level in and out
  input  wire logic [3:0] level_in,
  input  wire logic [3:0] rgb_brightness_level,
  output logic      [3:0] level_out
);

  logic [7:0] product;

  // brightness 0 gives the dimmest output, 15 passes the level unchanged
  always_comb begin
    product   = {4'h0, level_in} * ({4'h0, rgb_brightness_level} + 8'h01);
    level_out = product[7:4];
  end

endmodule

//--- osd_video_switch.sv
// behavioural video switch in front of the rgb dacs
module osd_video_switch (
  // clock
  input  wire logic        hclk,
  // from the resolver
  input  wire logic [11:0] rgb_in,
  input  wire logic        fast_blank_in,
  input  wire logic        blank_polarity_sel,
  // to the screen
  output logic      [11:0] picture,
  output logic      [11:0] video_src
);
  timeunit 1ns;
  timeprecision 1ns;
  // tuner video changes every clock so a stuck switch shows up
  initial video_src = 12'h123;
  always @(posedge hclk) video_src <= video_src + 12'h5a5;
  assign picture = (fast_blank_in ^ blank_polarity_sel) ? rgb_in : video_src;
endmodule

//--- osd_resolver_checker.sv
// assertions on the ports of the pixel colour resolver
module osd_resolver_checker (
  // clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pixel side
  input wire logic        flyback,
  input wire logic [11:0] rgb_out,
  input wire logic        fast_blank_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wr_q;
  logic [7:0] adr_q;
  logic       pol_q;
  logic [1:0] mode_q;
  // -----------------------------------------------
  // shadow of polarity and screen mode off the bus
  // -----------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      adr_q  <= 8'h00;
      pol_q  <= 1'b0;
      mode_q <= 2'b00;
    end else if (hready) begin
      wr_q  <= hsel && htrans[1] && hwrite && hsize == 3'b010;
      adr_q <= haddr;
      if (wr_q && adr_q == osd_colour_pkg::brightness_addr) begin
        pol_q <= hwdata[osd_colour_pkg::polarity_bit];
      end
      if (wr_q && adr_q == osd_colour_pkg::display_ctrl_addr) begin
        mode_q <= hwdata[1:0];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_always_a: assert property (hreadyout) else $error("wait state inserted");
  okay_resp_a: assert property (!hresp) else $error("error response given");
  rdata_hold_a: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data changed without a read");
  fly_rgb_a: assert property ($past(flyback) |-> rgb_out == {12{$past(pol_q)}})
    else $error("fly-back rgb level wrong");
  fly_blank_a: assert property ($past(flyback) |-> fast_blank_out == $past(pol_q))
    else $error("fly-back blank level wrong");
  video_black_a: assert property ($past(mode_q) == 2'b00 && !$past(flyback) |-> rgb_out == 12'h000)
    else $error("video mode not black");
  video_blank_a: assert property ($past(mode_q) == 2'b00 |-> fast_blank_out == $past(pol_q))
    else $error("video mode blank level wrong");
  rgb_blank_a: assert property (!$past(flyback) && rgb_out != 12'h000 |-> fast_blank_out != $past(pol_q))
    else $error("rgb shown with video blank level");
endmodule
bind osd_pixel_colour_attribute_resolver osd_resolver_checker i_osd_resolver_checker (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .flyback, .rgb_out,
  .fast_blank_out);

//--- test_osd_pixel_colour_attribute_resolver.sv
// self-checking bench for the pixel colour resolver
module test_osd_pixel_colour_attribute_resolver;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [11:0] s;
    logic [11:0] c;
    logic [1:0]  pl;
    logic [1:0]  ln;
    logic [4:0]  e;
  } row_type;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, row_start, char_valid, pixel_en, pol;
  logic        glyph_plane_low, glyph_plane_high, line_top, line_bottom, line_odd, in_text_area, flyback;
  logic        fast_blank_out;
  wire logic   hready;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  haddr;
  logic [11:0] char_word, rgb_out, picture, video;
  logic [31:0] hwdata, hrdata, rd;
  logic [11:0] m [4];
  int          err_total, n_compared, bri;
  // ctrl, serial code (0 none), character, planes, {top,bottom}, expected entry (bit4 transparent)
  row_type     rows [17] = '{'{8'h31, 12'h000, 12'h541, 2'b01, 2'b00, 5'h05},
    '{8'h31, 12'h000, 12'h541, 2'b00, 2'b00, 5'h08}, '{8'h31, 12'h802, 12'h541, 2'b00, 2'b00, 5'h02},
    '{8'h32, 12'h802, 12'h541, 2'b00, 2'b00, 5'h03}, '{8'h32, 12'h842, 12'h541, 2'b00, 2'b00, 5'h02},
    '{8'h33, 12'h802, 12'h541, 2'b00, 2'b00, 5'h10}, '{8'h33, 12'h842, 12'h541, 2'b00, 2'b00, 5'h02},
    '{8'h31, 12'hc80, 12'h541, 2'b01, 2'b00, 5'h0d}, '{8'h31, 12'h812, 12'h541, 2'b00, 2'b01, 5'h05},
    '{8'h31, 12'h822, 12'h541, 2'b00, 2'b10, 5'h05}, '{8'h31, 12'h000, 12'h580, 2'b10, 2'b00, 5'h06},
    '{8'h31, 12'h000, 12'h592, 2'b11, 2'b00, 5'h07}, '{8'h31, 12'h000, 12'h580, 2'b00, 2'b00, 5'h08},
    '{8'h31, 12'hc80, 12'h580, 2'b10, 2'b00, 5'h0e}, '{8'h31, 12'h000, 12'h581, 2'b10, 2'b00, 5'h08},
    '{8'h30, 12'h000, 12'h541, 2'b01, 2'b00, 5'h10}, '{8'h33, 12'h802, 12'h580, 2'b00, 2'b00, 5'h10}};
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  osd_pixel_colour_attribute_resolver i_osd_pixel_colour_attribute_resolver (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .row_start, .char_valid,
    .char_word, .pixel_en, .glyph_plane_low, .glyph_plane_high, .line_top, .line_bottom, .line_odd,
    .in_text_area, .flyback, .rgb_out, .fast_blank_out);
  osd_video_switch i_osd_video_switch (.hclk(hclk), .rgb_in(rgb_out), .fast_blank_in(fast_blank_out),
    .blank_polarity_sel(pol), .picture(picture), .video_src(video));
  function automatic logic [11:0] col(input int n);
    return {4'(n), 4'(15 - n), 4'(n ^ 6)};
  endfunction
  function automatic logic [11:0] lvl(input logic [11:0] c);
    for (int i = 0; i < 12; i += 4) c[i +: 4] = 4'((int'(c[i +: 4]) * (bri + 1)) >> 4);
    return c;
  endfunction
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // bus, character and pixel drivers
  // ----------------------------------------
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'b10, a, w, 3'b010};
    wait_ready();
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    wait_ready();
    rd = hrdata;
  endtask
  task automatic code(input logic [11:0] w);
    @(posedge hclk);
    {char_valid, char_word} <= {1'b1, w};
    @(posedge hclk);
    char_valid <= 1'b0;
  endtask
  task automatic rstart;
    @(posedge hclk);
    row_start <= 1'b1;
    @(posedge hclk);
    row_start <= 1'b0;
  endtask
  // e of 5'h1f only captures, for patterns judged by the caller
  task automatic pix(input logic [1:0] pl, input logic [1:0] ln, input logic [4:0] e);
    @(posedge hclk);
    {pixel_en, glyph_plane_high, glyph_plane_low, line_top, line_bottom} <= {1'b1, pl, ln};
    @(posedge hclk);
    pixel_en <= 1'b0;
    #1;
    if (e != 5'h1f) begin
      chk(rgb_out, e[4] ? 12'h000 : lvl(col(e[3:0])));
      chk(fast_blank_out, pol ^ !e[4]);
    end
  endtask
  initial begin
    {hsel, hwrite, row_start, char_valid, pixel_en, glyph_plane_low, glyph_plane_high} = '0;
    {line_top, line_bottom, line_odd, flyback, htrans, hsize, haddr, hwdata, char_word} = '0;
    {hclk, hresetn, pol, in_text_area} = 4'b0001;
    bri = 15;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk({rgb_out, fast_blank_out, hreadyout, hresp}, 15'h0002);
    bus(1'b0, osd_colour_pkg::brightness_addr, 32'h0);
    chk(rd, 32'h0000000f);
    bus(1'b0, osd_colour_pkg::display_ctrl_addr, 32'h0);
    chk(rd, 32'h00000000);
    bus(1'b0, osd_colour_pkg::text_end_addr, 32'h0);
    chk(rd, 32'h0000002f);
    for (int i = 0; i < 16; i++) bus(1'b1, 8'(64 + 4 * i), {20'hfffff, col(i)});
    bus(1'b0, 8'h64, 32'h0);
    chk(rd, {20'h0, col(9)});
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("reset and register test done");
    foreach (rows[i]) begin
      bus(1'b1, osd_colour_pkg::display_ctrl_addr, {24'h0, rows[i].ctrl});
      rstart();
      if (rows[i].s != 12'h000) code(rows[i].s);
      code(rows[i].c);
      pix(rows[i].pl, rows[i].ln, rows[i].e);
    end
    $display("table test done");
    bus(1'b1, osd_colour_pkg::display_ctrl_addr, 32'h31);
    rstart();
    code(12'h541);
    code(12'hc02);
    pix(2'b00, 2'b00, 5'h08);
    code(12'h541);
    pix(2'b00, 2'b00, 5'h02);
    rstart();
    code(12'hf02);
    pix(2'b01, 2'b00, 5'h02);
    code(12'h541);
    pix(2'b01, 2'b00, 5'h02);
    in_text_area <= 1'b0;
    pix(2'b01, 2'b00, 5'h03);
    in_text_area <= 1'b1;
    bus(1'b1, osd_colour_pkg::text_end_addr, 32'h1);
    rstart();
    for (int i = 1; i < 4; i++) code(12'h501 | 12'(i << 8) | 12'(i << 4));
    pix(2'b01, 2'b00, 5'h03);
    bus(1'b0, osd_colour_pkg::status_addr, 32'h0);
    chk(32'(rd[19:14]), 32'h2);
    bus(1'b1, osd_colour_pkg::text_end_addr, 32'h2f);
    $display("row attribute test done");
    for (int b = 0; b < 16; b += 7) begin
      bus(1'b1, osd_colour_pkg::brightness_addr, 32'(b));
      bri = b;
      rstart();
      code(12'h541);
      pix(2'b01, 2'b00, 5'h05);
    end
    bri = 15;
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, osd_colour_pkg::brightness_addr, {27'h0, p[0], 4'hf});
      pol = p[0];
      @(posedge hclk);
      flyback <= 1'b1;
      @(posedge hclk);
      flyback <= 1'b0;
      #1;
      chk({rgb_out, fast_blank_out}, {{12{pol}}, pol});
      chk(picture, video);
      pix(2'b01, 2'b00, 5'h05);
      chk(picture, col(5));
    end
    bus(1'b1, osd_colour_pkg::brightness_addr, 32'hf);
    pol = 1'b0;
    $display("brightness and blanking test done");
    bus(1'b1, osd_colour_pkg::display_ctrl_addr, 32'h35);
    rstart();
    code(12'h802);
    for (int lo = 0; lo < 2; lo++) begin
      @(posedge hclk);
      {line_odd, flyback} <= {lo[0], 1'b1};
      @(posedge hclk);
      flyback <= 1'b0;
      pix(2'b00, 2'b00, 5'h1f);
      m[2 * lo] = rgb_out;
      pix(2'b00, 2'b00, 5'h1f);
      m[2 * lo + 1] = rgb_out;
    end
    chk(m[0] ^ m[1], col(2) ^ col(3));
    chk(m[0] == col(2) || m[0] == col(3), 1);
    chk({m[2], m[3]}, {m[1], m[0]});
    $display("mesh test done");
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk({rgb_out, fast_blank_out, hreadyout, hresp}, 15'h0002);
    bus(1'b0, osd_colour_pkg::display_ctrl_addr, 32'h0);
    chk(rd, 32'h00000000);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule
